/* rtca_alarm.sv */
`timescale 1ns/1ps
// ==========================================================
// Alarm control: enable, repeat count, pulse level, registers
module rtca_alarm
   import rtca_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and power-on reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [31:0] RD_DATA,
   // Calendar side
   input wire logic HALF_TICK,
   input wire logic SEC_WRITE,
   input wire logic ROLLOVER_NEAR,
   input wire logic [RTCA_MATCH_W-1:0] FIELD_MATCH,
   input wire logic LEAP_YEAR,
   input wire logic ALARM_FEB29,
   // Outputs
   output logic ALARM_EVENT,
   output logic ALARM_PULSE,
   output logic CLK_OUT_EN,
   output logic IRQ
);

   // ==========================================================
   // Elaboration check: the decode needs the full low byte, and
   // a bus wider than 16 bits gains nothing here
   if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr_w
      $error("rtca_alarm: ADDR_W must be 8 to 16");
   end

   // ==========================================================
   // State
   logic enable_r, enable_nxt;
   logic wrap_r, wrap_nxt;
   logic piv_r, piv_nxt;
   logic [3:0] mask_r, mask_nxt;
   logic [7:0] rpt_r, rpt_nxt;
   logic on_r;
   logic oe_r;
   logic phase_r;
   logic unstable_r;
   logic pulse_r;
   logic event_r;
   logic [RTCA_IRQ_W-1:0] stat_r, stat_nxt;
   logic [RTCA_IRQ_W-1:0] imask_r;
   logic [31:0] rd_data_r;

   // ==========================================================
   // Address decode
   wire [7:0] addr8 = ADDR[7:0];
   wire upper_zero = (ADDR >> 8) == '0;
   wire sel_alarm = upper_zero && addr8 == RTCA_ALARM_CTL_OFS;
   wire sel_clock = upper_zero && addr8 == RTCA_CLOCK_CTL_OFS;
   wire sel_stat = upper_zero && addr8 == RTCA_IRQ_STAT_OFS;
   wire sel_imask = upper_zero && addr8 == RTCA_IRQ_MASK_OFS;
   wire wr_alarm = WR_EN && sel_alarm;
   wire wr_clock = WR_EN && sel_clock;
   wire wr_imask = WR_EN && sel_imask;
   wire rd_stat = RD_EN && sel_stat;
   // Write-data fields, named once for next-state logic and checks
   wire [7:0] wr_rpt = WR_DATA[RTCA_RPT_LSB +: 8];
   wire [3:0] wr_mask = WR_DATA[RTCA_MASK_LSB +: 4];
   wire wr_piv = WR_DATA[RTCA_PIV_BIT];

   // ==========================================================
   // Event qualification
   logic interval_hit;

   rtca_match u_match (
      .code(mask_r),
      .match(FIELD_MATCH),
      .phase(phase_r),
      .leap_year(LEAP_YEAR),
      .alarm_feb29(ALARM_FEB29),
      .hit(interval_hit)
   );

   // Fires on a half-second tick only while on and enabled; with the
   // module off the calendar is frozen, so no event can be trusted
   wire armed = on_r & enable_r; // see RULE2
   wire alarm_fire = HALF_TICK & armed & interval_hit; // see RULE18
   // Count zero is the last trigger, so a value N gives N+1 events
   wire at_zero = rpt_r == RTCA_RPT_RST;
   wire expire = alarm_fire & at_zero & ~wrap_r; // see RULE5

   // ==========================================================
   // Alarm control next state; a software write outranks an event
   // in the same cycle, so software sees what it wrote
   always_comb begin
      enable_nxt = enable_r;
      wrap_nxt = wrap_r;
      piv_nxt = piv_r;
      mask_nxt = mask_r;
      rpt_nxt = rpt_r;
      if (wr_alarm) begin
         // Upper half ignored on write
         enable_nxt = WR_DATA[RTCA_ENABLE_BIT]; // see RULE1
         wrap_nxt = WR_DATA[RTCA_WRAP_BIT];
         mask_nxt = wr_mask;
         rpt_nxt = wr_rpt;
         // Level frozen while the alarm runs
         if (!enable_r) begin
            piv_nxt = wr_piv; // see RULE7
         end
      end else if (alarm_fire) begin
         if (!at_zero) begin
            rpt_nxt = rpt_r - 8'h01; // see RULE6
         end else if (wrap_r) begin
            rpt_nxt = RTCA_RPT_WRAP; // see RULE4
         end else begin
            enable_nxt = 1'b0; // see RULE3
         end
      end
   end

   // Power-on reset only; no other reset reaches these bits
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin // see RULE15
         enable_r <= 1'b0;
         wrap_r <= 1'b0;
         piv_r <= 1'b0;
         mask_r <= RTCA_MASK_RST;
         rpt_r <= RTCA_RPT_RST;
      end else begin
         enable_r <= enable_nxt;
         wrap_r <= wrap_nxt;
         piv_r <= piv_nxt;
         mask_r <= mask_nxt;
         rpt_r <= rpt_nxt;
      end
   end

   // ==========================================================
   // Clock control bits, phase and unstable flag
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         on_r <= 1'b0;
         oe_r <= 1'b0;
         phase_r <= 1'b0;
         unstable_r <= 1'b0;
      end else begin
         if (wr_clock) begin
            on_r <= WR_DATA[RTCA_ON_BIT];
            oe_r <= WR_DATA[RTCA_OE_BIT];
         end
         // Seconds write restarts the second at its first half
         if (SEC_WRITE) begin
            phase_r <= 1'b0; // see RULE16
         end else if (HALF_TICK && on_r) begin
            phase_r <= ~phase_r;
         end
         // Warns software that a rollover may tear a read
         unstable_r <= on_r & ROLLOVER_NEAR; // see RULE9
      end
   end

   // ==========================================================
   // Alarm pulse: follows the initial level until enabled
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pulse_r <= 1'b0;
         event_r <= 1'b0;
      end else begin
         event_r <= alarm_fire;
         if (!enable_r) begin
            pulse_r <= piv_r; // see RULE7
         end else if (alarm_fire) begin
            pulse_r <= ~pulse_r; // see RULE19
         end
      end
   end

   // ==========================================================
   // Interrupt status; a new event wins over the read clear
   always_comb begin
      stat_nxt = rd_stat ? '0 : stat_r;
      if (alarm_fire) begin
         stat_nxt[RTCA_IRQ_EVENT_BIT] = 1'b1;
      end
      if (expire) begin
         stat_nxt[RTCA_IRQ_DONE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         stat_r <= '0;
         imask_r <= '0;
      end else begin
         stat_r <= stat_nxt;
         if (wr_imask) begin
            imask_r <= WR_DATA[RTCA_IRQ_W-1:0];
         end
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   wire piv_view = enable_r ? pulse_r : piv_r; // see RULE8
   wire [31:0] alarm_word = {16'h0000, enable_r, wrap_r, piv_view,
                             unstable_r, mask_r, rpt_r}; // see RULE1
   wire [31:0] clock_word = {16'h0000, on_r, 12'h000, unstable_r,
                             phase_r, oe_r};
   wire [31:0] stat_word = {{(32-RTCA_IRQ_W){1'b0}}, stat_r};
   wire [31:0] imask_word = {{(32-RTCA_IRQ_W){1'b0}}, imask_r};
   wire [31:0] rd_mux = sel_alarm ? alarm_word :
                        sel_clock ? clock_word :
                        sel_stat ? stat_word :
                        sel_imask ? imask_word : 32'h0000_0000;

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rd_data_r <= 32'h0000_0000;
      end else begin
         rd_data_r <= RD_EN ? rd_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Outputs
   assign RD_DATA = rd_data_r;
   assign ALARM_EVENT = event_r;
   assign CLK_OUT_EN = on_r & oe_r; // see RULE17
   assign ALARM_PULSE = pulse_r & on_r & oe_r; // see RULE17
   assign IRQ = |(stat_r & imask_r);

   // ==========================================================
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   chk_disabled_silent: assert property ( // see RULE2
      !enable_r |=> !ALARM_EVENT)
      else $error("alarm fired while disabled");

   chk_auto_disable: assert property ( // see RULE3
      alarm_fire && at_zero && !wrap_r && !wr_alarm |=> !enable_r)
      else $error("enable not cleared at last repeat");

   chk_wrap_reload: assert property ( // see RULE4
      alarm_fire && at_zero && wrap_r && !wr_alarm
      |=> rpt_r == 8'hff && enable_r)
      else $error("repeat counter did not wrap");

   chk_count_down: assert property ( // see RULE6
      alarm_fire && !at_zero && !wr_alarm
      |=> rpt_r == $past(rpt_r) - 8'h01)
      else $error("repeat counter did not decrement");

   chk_level_frozen: assert property ( // see RULE8
      enable_r && wr_alarm |=> piv_r == $past(piv_r))
      else $error("initial level changed while enabled");

   chk_pulse_idle: assert property ( // see RULE7
      !enable_r ##1 !enable_r |-> pulse_r == $past(piv_r))
      else $error("pulse does not follow initial level");

   chk_pulse_toggle: assert property ( // see RULE19
      alarm_fire |=> pulse_r != $past(pulse_r) && ALARM_EVENT)
      else $error("pulse did not toggle on event");

   chk_phase_clear: assert property ( // see RULE16
      SEC_WRITE |=> !phase_r)
      else $error("phase not cleared by seconds write");

   chk_pin_gate: assert property ( // see RULE17
      !(on_r && oe_r) |-> !ALARM_PULSE && !CLK_OUT_EN)
      else $error("pin active without on and enable");

   chk_reserved_zero: assert property ( // see RULE1
      RD_EN && sel_alarm |=> RD_DATA[31:16] == 16'h0000)
      else $error("reserved alarm bits read nonzero");

   chk_sticky_event: assert property (
      alarm_fire |=> stat_r[RTCA_IRQ_EVENT_BIT] ##0
      (IRQ || !imask_r[RTCA_IRQ_EVENT_BIT]))
      else $error("event status lost");

   chk_event_follow: assert property ( // see RULE18
      alarm_fire |=> ALARM_EVENT)
      else $error("alarm event pulse missing");

   chk_count_floor: assert property ( // see RULE4
      alarm_fire && at_zero && !wrap_r && !wr_alarm
      |=> rpt_r == RTCA_RPT_RST)
      else $error("repeat counter left zero without wrap");

   chk_level_write: assert property ( // see RULE7
      !enable_r && wr_alarm |=> piv_r == $past(wr_piv))
      else $error("initial level write lost while disabled");

   chk_pulse_start: assert property ( // see RULE19
      $rose(enable_r) |-> pulse_r == $past(piv_r))
      else $error("pulse did not start at initial level");

   chk_unstable_flag: assert property ( // see RULE9
      on_r && ROLLOVER_NEAR |=> unstable_r)
      else $error("unstable flag not raised");

   chk_phase_toggle: assert property ( // see RULE16
      HALF_TICK && on_r && !SEC_WRITE |=> phase_r != $past(phase_r))
      else $error("phase did not toggle on half tick");

   chk_reserved_code: assert property ( // see RULE13
      mask_r > 4'h9 |-> !interval_hit)
      else $error("reserved interval code produced a hit");

   // A read with no event in the same cycle must empty the status
   chk_status_clear: assert property (
      rd_stat && !alarm_fire |=> stat_r == '0)
      else $error("status not cleared by read");

   chk_write_lands: assert property ( // see RULE1
      wr_alarm |=> rpt_r == $past(wr_rpt) && mask_r == $past(wr_mask))
      else $error("alarm control write lost");

   // ==========================================================
   // Cover points for the main scenarios
   cov_wrap: cover property (alarm_fire && at_zero && wrap_r);
   cov_expire: cover property (expire ##1 !enable_r);
   cov_unstable_read: cover property (RD_EN && sel_alarm && unstable_r);
   cov_year_hit: cover property (alarm_fire && mask_r == 4'h9);
   cov_level_live: cover property (RD_EN && sel_alarm && enable_r);

endmodule : rtca_alarm

/* rtca_alarm_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the alarm control block
module rtca_alarm_tb;
   import rtca_pkg::*;

   // Bench-driven inputs and observed outputs
   logic ref_clk, rst_n, wr_en, rd_en, half_tick, sec_write, roll_near;
   logic leap_year, alarm_feb29;
   logic [7:0] addr;
   logic [31:0] wr_data, rd_data, d;
   logic [RTCA_MATCH_W-1:0] field_match;
   logic alarm_event, alarm_pulse, clk_out_en, irq, ev;
   int fails, checks, n;

   rtca_alarm rtca_alarm_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
      .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
      .RD_DATA(rd_data), .HALF_TICK(half_tick), .SEC_WRITE(sec_write),
      .ROLLOVER_NEAR(roll_near), .FIELD_MATCH(field_match),
      .LEAP_YEAR(leap_year), .ALARM_FEB29(alarm_feb29),
      .ALARM_EVENT(alarm_event), .ALARM_PULSE(alarm_pulse),
      .CLK_OUT_EN(clk_out_en), .IRQ(irq));

   // ==========================================================
   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Compare tasks and verdict
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk1

   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Bus and calendar drivers, all changes just after the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= v;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      // One more edge so the new register value is visible
      @(posedge ref_clk);
   endtask : wr

   // Read data stand only in the cycle after the strobe; they are
   // taken at the edge that closes that cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(posedge ref_clk);
      v = rd_data;
   endtask : rd

   // Event pulse is looked at in the one cycle it stands
   task automatic tick(output logic e);
      @(posedge ref_clk);
      half_tick <= 1'b1;
      @(posedge ref_clk);
      half_tick <= 1'b0;
      @(posedge ref_clk);
      e = alarm_event;
   endtask : tick

   task automatic sec_wr;
      @(posedge ref_clk);
      sec_write <= 1'b1;
      @(posedge ref_clk);
      sec_write <= 1'b0;
   endtask : sec_wr

   // Phase cleared first, so two ticks cover both halves of a second
   task automatic run_code(input logic [3:0] c, input logic [7:0] m,
                           input int exp);
      wr(RTCA_ALARM_CTL_OFS, 32'h0000c0ff | (32'(c) << RTCA_MASK_LSB));
      field_match <= m;
      sec_wr();
      n = 0;
      repeat (2) begin
         tick(ev);
         n += int'(ev);
      end
      chk32(32'(n), 32'(exp));
   endtask : run_code

   // ==========================================================
   // Scenarios
   task automatic t_reset_and_map;
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d, 32'h00000000);
      rd(RTCA_CLOCK_CTL_OFS, d);
      chk32(d, 32'h00000000);
      chk1(clk_out_en, 1'b0);
      rd(8'h10, d);
      chk32(d, 32'h00000000);
   endtask : t_reset_and_map

   task automatic t_phase_and_pin;
      wr(RTCA_CLOCK_CTL_OFS, 32'h00008000);
      chk1(clk_out_en, 1'b0);
      wr(RTCA_CLOCK_CTL_OFS, 32'h00008001);
      chk1(clk_out_en, 1'b1);
      sec_wr();
      rd(RTCA_CLOCK_CTL_OFS, d);
      chk32(d, 32'h00008001);
      tick(ev);
      chk1(ev, 1'b0);
      rd(RTCA_CLOCK_CTL_OFS, d);
      chk32(d, 32'h00008003);
      sec_wr();
      rd(RTCA_CLOCK_CTL_OFS, d);
      chk32(d, 32'h00008001);
   endtask : t_phase_and_pin

   // Count of 2 gives three events, then enable drops by itself
   task automatic t_repeat_expire;
      logic [31:0] exp_v [4];
      exp_v = '{32'h8001, 32'h8000, 32'h0000, 32'h0000};
      field_match <= 8'hff;
      rd(RTCA_IRQ_STAT_OFS, d);
      wr(RTCA_IRQ_MASK_OFS, 32'h0);
      wr(RTCA_ALARM_CTL_OFS, 32'h00008002);
      for (int i = 0; i < 4; i++) begin
         tick(ev);
         chk1(ev, i < 3);
         rd(RTCA_ALARM_CTL_OFS, d);
         chk32(d & 32'h0000dfff, exp_v[i]);
      end
      chk1(irq, 1'b0);
      wr(RTCA_IRQ_MASK_OFS, 32'h2);
      chk1(irq, 1'b1);
      rd(RTCA_IRQ_STAT_OFS, d);
      chk32(d, 32'h00000003);
      chk1(irq, 1'b0);
      rd(RTCA_IRQ_STAT_OFS, d);
      chk32(d, 32'h00000000);
   endtask : t_repeat_expire

   task automatic t_wrap;
      wr(RTCA_ALARM_CTL_OFS, 32'h0000c000);
      tick(ev);
      chk1(ev, 1'b1);
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d & 32'h0000dfff, 32'h0000c0ff);
      wr(RTCA_IRQ_MASK_OFS, 32'h1);
      chk1(irq, 1'b1);
      rd(RTCA_IRQ_STAT_OFS, d);
      chk32(d, 32'h00000001);
   endtask : t_wrap

   // Stored level while idle, live pulse while armed
   task automatic t_pulse_level;
      // Disarm first: the level bit ignores writes while armed
      wr(RTCA_ALARM_CTL_OFS, 32'h00000000);
      wr(RTCA_ALARM_CTL_OFS, 32'h00002000);
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d, 32'h00002000);
      chk1(alarm_pulse, 1'b1);
      wr(RTCA_ALARM_CTL_OFS, 32'h0000e0ff);
      tick(ev);
      chk1(alarm_pulse, 1'b0);
      wr(RTCA_ALARM_CTL_OFS, 32'h0000e0ff);
      rd(RTCA_ALARM_CTL_OFS, d);
      chk1(d[RTCA_PIV_BIT], 1'b0);
      tick(ev);
      chk1(alarm_pulse, 1'b1);
      rd(RTCA_ALARM_CTL_OFS, d);
      chk1(d[RTCA_PIV_BIT], 1'b1);
      wr(RTCA_CLOCK_CTL_OFS, 32'h00008000);
      chk1(alarm_pulse, 1'b0);
      wr(RTCA_CLOCK_CTL_OFS, 32'h00008001);
   endtask : t_pulse_level

   task automatic t_mask_codes;
      leap_year <= 1'b1;
      for (int c = 0; c < 10; c++) begin
         run_code(4'(c), 8'hff, (c == 0) ? 2 : 1);
      end
      run_code(RTCA_IV_SEC10, 8'h01, 1);
      run_code(RTCA_IV_MIN, 8'h01, 0);
      for (int c = 6; c < 10; c++) begin
         run_code(4'(c), 8'h00, 0);
      end
      alarm_feb29 <= 1'b1;
      leap_year <= 1'b0;
      run_code(RTCA_IV_YEAR, 8'hff, 0);
      leap_year <= 1'b1;
      run_code(RTCA_IV_YEAR, 8'hff, 1);
      alarm_feb29 <= 1'b0;
   endtask : t_mask_codes

   // Read-only warning flag follows the rollover level
   task automatic t_unstable;
      // Fields written only while the flag is clear
      wr(RTCA_ALARM_CTL_OFS, 32'h00000000);
      wr(RTCA_ALARM_CTL_OFS, 32'h00001000);
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d, 32'h00000000);
      roll_near <= 1'b1;
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d, 32'h00001000);
      rd(RTCA_CLOCK_CTL_OFS, d);
      chk1(d[RTCA_CC_UNSTABLE_BIT], 1'b1);
      roll_near <= 1'b0;
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d, 32'h00000000);
   endtask : t_unstable

   task automatic t_second_reset;
      wr(RTCA_ALARM_CTL_OFS, 32'h000045a5);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(RTCA_ALARM_CTL_OFS, d);
      chk32(d, 32'h00000000);
   endtask : t_second_reset

   // ==========================================================
   // Main sequence
   initial begin
      fails = 0;
      checks = 0;
      rst_n = 1'b0;
      {wr_en, rd_en, half_tick, sec_write, roll_near} = '0;
      {leap_year, alarm_feb29} = '0;
      addr = 8'h00;
      wr_data = 32'h0;
      field_match = 8'h00;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset_and_map();
      t_phase_and_pin();
      t_repeat_expire();
      t_wrap();
      t_pulse_level();
      t_mask_codes();
      t_unstable();
      t_second_reset();
      give_verdict();
   end

endmodule : rtca_alarm_tb

/* rtca_match.sv */
`timescale 1ns/1ps
// ==========================================================
// Interval decoder: which equal fields must line up for a hit
module rtca_match
   import rtca_pkg::*;
(
   // Selection
   input wire logic [3:0] code,
   // Calendar state
   input wire logic [RTCA_MATCH_W-1:0] match,
   input wire logic phase,
   input wire logic leap_year,
   input wire logic alarm_feb29,
   // Result
   output logic hit
);

   // Cumulative field groups, each interval adds one field; week and month both build on the hour group
   wire sec01_ok = match[RTCA_M_SEC01];
   wire sec_ok = sec01_ok & match[RTCA_M_SEC10];
   wire min01_ok = sec_ok & match[RTCA_M_MIN01];
   wire min_ok = min01_ok & match[RTCA_M_MIN10];
   wire hour_ok = min_ok & match[RTCA_M_HOUR];
   wire week_ok = hour_ok & match[RTCA_M_WDAY];
   wire month_ok = hour_ok & match[RTCA_M_DAY];
   wire year_ok = month_ok & match[RTCA_M_MONTH];
   // Leap day only counts in a leap year
   wire leap_ok = ~alarm_feb29 | leap_year; // see RULE12
   // Whole-second points fall on the second-half edge
   wire sec_edge = phase;

   // Interval select; reserved codes never hit
   always_comb begin
      case (code)
         RTCA_IV_HALF: hit = 1'b1; // see RULE10
         RTCA_IV_SEC: hit = sec_edge;
         RTCA_IV_SEC10: hit = sec_edge & sec01_ok;
         RTCA_IV_MIN: hit = sec_edge & sec_ok;
         RTCA_IV_MIN10: hit = sec_edge & min01_ok;
         RTCA_IV_HOUR: hit = sec_edge & min_ok;
         RTCA_IV_DAY: hit = sec_edge & hour_ok; // see RULE11
         RTCA_IV_WEEK: hit = sec_edge & week_ok;
         RTCA_IV_MONTH: hit = sec_edge & month_ok;
         RTCA_IV_YEAR: hit = sec_edge & year_ok & leap_ok; // see RULE12
         default: hit = 1'b0; // see RULE13
      endcase
   end

endmodule : rtca_match

/* rtca_pkg.sv */
// Operation
// (RULE1) Upper sixteen control bits reserved, write zero
// (RULE2) Enable bit gates all alarm events
// (RULE3) Event at count zero, no wrap: clear enable
// (RULE4) Wrap option reloads counter from 00 to FF
// (RULE5) Counter value N gives N plus one triggers
// (RULE6) Every alarm event decrements the repeat counter; at 00 without wrap the code holds it at 00
// (RULE7) Initial level writable and used while disabled
// (RULE8) Enabled: initial level reads live pulse state
// (RULE9) Unstable flag warns of half-second rollover
// (RULE10) Short interval mask codes, half-second to hour
// (RULE11) Long interval mask codes, day to year
// (RULE12) Yearly February 29 alarm fires leap years only
// (RULE13) Reserved mask codes never programmed by software
// (RULE14) Software avoids field writes while unstable flag set
// (RULE15) Only power-on reset clears alarm control
// (RULE16) Half-second phase flag, cleared by seconds write
// (RULE17) Pin enable is output enable AND module on
// (RULE18) Event when unmasked fields match at interval
// (RULE19) Pulse starts at initial level, toggles per event
package rtca_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] RTCA_ALARM_CTL_OFS = 8'h00;
   localparam logic [7:0] RTCA_CLOCK_CTL_OFS = 8'h04;
   localparam logic [7:0] RTCA_IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] RTCA_IRQ_MASK_OFS = 8'h0c;

   // ==========================================================
   // Alarm control fields
   localparam int RTCA_ENABLE_BIT = 15;
   localparam int RTCA_WRAP_BIT = 14;
   localparam int RTCA_PIV_BIT = 13;
   localparam int RTCA_UNSTABLE_BIT = 12;
   localparam int RTCA_MASK_LSB = 8;
   localparam int RTCA_RPT_LSB = 0;

   // ==========================================================
   // Clock control fields
   localparam int RTCA_ON_BIT = 15;
   localparam int RTCA_CC_UNSTABLE_BIT = 2;
   localparam int RTCA_PHASE_BIT = 1;
   localparam int RTCA_OE_BIT = 0;

   // ==========================================================
   // Interrupt status fields
   localparam int RTCA_IRQ_EVENT_BIT = 0;
   localparam int RTCA_IRQ_DONE_BIT = 1;
   localparam int RTCA_IRQ_W = 2;

   // ==========================================================
   // Reset values and counter limits
   localparam logic [7:0] RTCA_RPT_RST = 8'h00;
   localparam logic [7:0] RTCA_RPT_WRAP = 8'hff;
   localparam logic [3:0] RTCA_MASK_RST = 4'h0;

   // ==========================================================
   // Match interval codes
   typedef enum logic [3:0] {
      RTCA_IV_HALF = 4'h0,
      RTCA_IV_SEC = 4'h1,
      RTCA_IV_SEC10 = 4'h2,
      RTCA_IV_MIN = 4'h3,
      RTCA_IV_MIN10 = 4'h4,
      RTCA_IV_HOUR = 4'h5,
      RTCA_IV_DAY = 4'h6,
      RTCA_IV_WEEK = 4'h7,
      RTCA_IV_MONTH = 4'h8,
      RTCA_IV_YEAR = 4'h9
   } rtca_interval_t;

   // ==========================================================
   // Field-equality vector positions
   localparam int RTCA_M_SEC01 = 0;
   localparam int RTCA_M_SEC10 = 1;
   localparam int RTCA_M_MIN01 = 2;
   localparam int RTCA_M_MIN10 = 3;
   localparam int RTCA_M_HOUR = 4;
   localparam int RTCA_M_WDAY = 5;
   localparam int RTCA_M_DAY = 6;
   localparam int RTCA_M_MONTH = 7;
   localparam int RTCA_MATCH_W = 8;

endpackage : rtca_pkg
